/* channel_framer_regs.svh */
`ifndef CHANNEL_FRAMER_REGS_SVH
`define CHANNEL_FRAMER_REGS_SVH

// Header bytes in wire order.
`define FRM_SYNC_HI       8'h55
`define FRM_SYNC_LO       8'hAA
`define FRM_HDR_BYTES     11'h004

// Command codes.
`define FRM_CMD_DATA      8'h00
`define FRM_CMD_VERSION   8'h01
`define FRM_CMD_BIND      8'h02
`define FRM_CMD_CLEAR     8'h03

// Reset values.
`define FRM_TARGET_IP_RST   32'h0000_0000
`define FRM_TARGET_PORT_RST 16'h0000

`endif

/* framer_pkg.sv */
package framer_pkg;

    typedef enum logic [2:0] {
        RX_HUNT,
        RX_SYNC_LO,
        RX_CMD,
        RX_CNT,
        RX_DATA
    } rx_state_t;

endpackage : framer_pkg

/* framer_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface framer_if #(
    parameter int AW = 8
) ();
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [31:0]   wr_data;
    logic [AW-1:0] rd_addr;
    logic [31:0]   rd_data;
    logic          tx_start;
    logic          tx_version;
    logic [7:0]    tx_count;
    logic          tx_busy;

    modport ctl (output wr_en, wr_addr, wr_data, rd_addr, tx_start, tx_version, tx_count,
                 input rd_data, tx_busy);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
    modport tx  (input tx_start, tx_version, tx_count, output tx_busy);
endinterface : framer_if

`default_nettype wire

/* sample_mem.sv */
`timescale 1ns/10ps
`default_nettype none

module sample_mem #(
    parameter int AW = 8
) (
    // Clock
    input wire logic mclk,
    // Ports
    framer_if.mem    mp
);
    logic [31:0] mem_r [0:(1<<AW)-1];
    logic [31:0] rd_data_r;

    always_ff @(posedge mclk) begin
        if (mp.wr_en) begin
            mem_r[mp.wr_addr] <= mp.wr_data;
        end
    end

    // Read data always comes from a register, one cycle after the address.
    always_ff @(posedge mclk) begin
        rd_data_r <= mem_r[mp.rd_addr];
    end

    assign mp.rd_data = rd_data_r;
endmodule : sample_mem

`default_nettype wire

/* packet_tx.sv */
`timescale 1ns/10ps
`default_nettype none
`include "channel_framer_regs.svh"

module packet_tx #(
    parameter logic [31:0] PROTO_VERSION = 32'h0000_0001
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Request from the controller
    framer_if.tx             rq,
    // Sample fetch
    output logic      [7:0]  word_idx,
    input  wire logic [31:0] word_in,
    // Byte stream out
    output logic      [7:0]  tx_byte,
    output logic             tx_valid,
    input  wire logic        tx_ready
);
    logic        active_r;
    logic        ver_r;
    logic [7:0]  cnt_r;
    logic [10:0] pos_r;
    logic [10:0] total_r;
    logic [7:0]  byte_r;
    logic        valid_r;
    logic        load;

    function automatic logic [7:0] next_byte(input logic [10:0] pos, input logic ver,
                                             input logic [7:0] cnt, input logic [31:0] w);
        logic [31:0] word;
        word = ver ? PROTO_VERSION : w;
        if (pos < `FRM_HDR_BYTES) begin
            unique case (pos[1:0])
                2'h0: next_byte = `FRM_SYNC_HI;
                2'h1: next_byte = `FRM_SYNC_LO;
                2'h2: next_byte = ver ? `FRM_CMD_VERSION : `FRM_CMD_DATA;
                2'h3: next_byte = ver ? 8'h01 : cnt;
            endcase
        end else begin
            unique case (pos[1:0])
                2'h0: next_byte = word[31:24];
                2'h1: next_byte = word[23:16];
                2'h2: next_byte = word[15:8];
                2'h3: next_byte = word[7:0];
            endcase
        end
    endfunction : next_byte

    assign load     = active_r && (!valid_r || tx_ready);
    assign rq.tx_busy = active_r || valid_r;
    // The fetch index is held for the four bytes of a word; the sample source must hold its data.
    assign word_idx = (pos_r < `FRM_HDR_BYTES) ? 8'h00 : 8'(pos_r[10:2] - 9'h001);
    assign tx_byte  = byte_r;
    assign tx_valid = valid_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            active_r <= 1'b0;
            ver_r    <= 1'b0;
            cnt_r    <= 8'h00;
            pos_r    <= 11'h000;
            total_r  <= 11'h000;
        end else if (rq.tx_start && !rq.tx_busy) begin
            active_r <= 1'b1;
            ver_r    <= rq.tx_version;
            cnt_r    <= rq.tx_count;
            pos_r    <= 11'h000;
            total_r  <= {1'b0, (rq.tx_version ? 8'h01 : rq.tx_count), 2'h0} + `FRM_HDR_BYTES;
        end else if (load) begin
            pos_r <= pos_r + 11'h001;
            if (pos_r == total_r - 11'h001) begin
                active_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            byte_r  <= 8'h00;
            valid_r <= 1'b0;
        end else if (load) begin
            byte_r  <= next_byte(pos_r, ver_r, cnt_r, word_in);
            valid_r <= 1'b1;
        end else if (tx_ready) begin
            valid_r <= 1'b0;
        end
    end

    property p_tx_sync_first;
        @(posedge mclk) disable iff (!rstn)
        rq.tx_start && !rq.tx_busy |-> ##2 (tx_valid && tx_byte == `FRM_SYNC_HI);
    endproperty
    a_tx_sync_first: assert property (p_tx_sync_first) else $error("packet did not open with sync");

    property p_tx_busy_hold;
        @(posedge mclk) disable iff (!rstn)
        rq.tx_start && !rq.tx_busy |=> rq.tx_busy [*4];
    endproperty
    a_tx_busy_hold: assert property (p_tx_busy_hold) else $error("busy dropped inside header");

    c_tx_version: cover property (@(posedge mclk) disable iff (!rstn) rq.tx_start && rq.tx_version);
endmodule : packet_tx

`default_nettype wire

/* channel_packet_framer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "channel_framer_regs.svh"

module channel_packet_framer #(
    parameter int          AW            = 8,
    parameter logic [31:0] PROTO_VERSION = 32'h0000_0001,
    // Factory address; the value is arbitrary.
    parameter logic [47:0] FACTORY_MAC   = 48'h02_00_00_00_00_01
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rstn,
    // Receive byte stream from the datagram link
    input  wire logic [7:0]    rx_byte,
    input  wire logic          rx_valid,
    input  wire logic          rx_first,
    input  wire logic [31:0]   rx_src_ip,
    input  wire logic [15:0]   rx_src_port,
    // Transmit byte stream to the datagram link
    output logic      [7:0]    tx_byte,
    output logic               tx_valid,
    input  wire logic          tx_ready,
    output logic      [31:0]   tx_dst_ip,
    output logic      [15:0]   tx_dst_port,
    output logic               target_valid,
    // Circuit transmit side
    input  wire logic          send,
    input  wire logic [7:0]    tx_pkt_size,
    output logic      [7:0]    tx_word_idx,
    input  wire logic [31:0]   tx_word_in,
    output logic               tx_busy,
    // Circuit receive side
    input  wire logic          rx_reset,
    input  wire logic [7:0]    rx_pkt_size,
    output logic               header_found,
    output logic               rx_busy,
    input  wire logic [AW-1:0] rx_chan_sel,
    output logic      [31:0]   rx_chan_data,
    // Station address
    input  wire logic [47:0]   mac_user,
    input  wire logic          mac_user_en,
    output logic      [47:0]   mac_addr
);
    framer_if #(.AW(AW)) core ();

    framer_pkg::rx_state_t state_r;
    framer_pkg::rx_state_t cur;
    logic [7:0]    cmd_r;
    logic [7:0]    cnt_r;
    logic [1:0]    bcnt_r;
    logic [7:0]    widx_r;
    logic [7:0]    fill_r;
    logic [23:0]   shift_r;
    logic          take;
    logic          cnt_byte;
    logic          word_done;
    logic [31:0]   target_ip_r;
    logic [15:0]   target_port_r;
    logic          target_valid_r;
    logic          send_prev_r;
    logic          send_rise;
    logic          send_pend_r;
    logic          ver_pend_r;
    logic          ver_set;
    logic          start;
    logic          zero_r;
    logic [47:0]   mac_r;

    // A first byte of a new datagram always restarts the parser, so a truncated datagram
    // never swallows the header of the next one.
    assign cur       = rx_first ? framer_pkg::RX_HUNT : state_r;
    assign take      = rx_valid && !rx_reset;
    assign cnt_byte  = take && cur == framer_pkg::RX_CNT;
    assign word_done = take && cur == framer_pkg::RX_DATA && bcnt_r == 2'h3;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= framer_pkg::RX_HUNT;
        end else if (rx_reset) begin
            state_r <= framer_pkg::RX_HUNT;
        end else if (rx_valid) begin
            unique case (cur)
                framer_pkg::RX_HUNT: begin
                    if (rx_byte == `FRM_SYNC_HI) begin
                        state_r <= framer_pkg::RX_SYNC_LO;
                    end else begin
                        state_r <= framer_pkg::RX_HUNT;
                    end
                end
                framer_pkg::RX_SYNC_LO: begin
                    if (rx_byte == `FRM_SYNC_LO) begin
                        state_r <= framer_pkg::RX_CMD;
                    end else if (rx_byte == `FRM_SYNC_HI) begin
                        state_r <= framer_pkg::RX_SYNC_LO;
                    end else begin
                        state_r <= framer_pkg::RX_HUNT;
                    end
                end
                framer_pkg::RX_CMD: begin
                    state_r <= framer_pkg::RX_CNT;
                end
                framer_pkg::RX_CNT: begin
                    if (rx_byte == 8'h00) begin
                        state_r <= framer_pkg::RX_HUNT;
                    end else begin
                        state_r <= framer_pkg::RX_DATA;
                    end
                end
                framer_pkg::RX_DATA: begin
                    if (word_done && widx_r == cnt_r - 8'h01) begin
                        state_r <= framer_pkg::RX_HUNT;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cmd_r   <= 8'h00;
            cnt_r   <= 8'h00;
            bcnt_r  <= 2'h0;
            widx_r  <= 8'h00;
            shift_r <= 24'h00_0000;
        end else if (take) begin
            if (cur == framer_pkg::RX_CMD) begin
                cmd_r <= rx_byte;
            end
            if (cur == framer_pkg::RX_CNT) begin
                cnt_r  <= rx_byte;
                bcnt_r <= 2'h0;
                widx_r <= 8'h00;
            end
            if (cur == framer_pkg::RX_DATA) begin
                shift_r <= {shift_r[15:0], rx_byte};
                bcnt_r  <= bcnt_r + 2'h1;
                if (word_done) begin
                    widx_r <= widx_r + 8'h01;
                end
            end
        end
    end

    // Fill counts channels stored since the last sample header; an abort leaves it as is.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fill_r <= 8'h00;
        end else if (cnt_byte && cmd_r == `FRM_CMD_DATA) begin
            fill_r <= 8'h00;
        end else if (core.wr_en) begin
            fill_r <= widx_r + 8'h01;
        end
    end

    // Words of control packets are skipped; unknown commands are consumed without effect.
    assign core.wr_en   = word_done && cmd_r == `FRM_CMD_DATA;
    assign core.wr_addr = AW'(widx_r);
    assign core.wr_data = {shift_r, rx_byte};
    assign core.rd_addr = rx_chan_sel;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            zero_r <= 1'b1;
        end else begin
            zero_r <= (8'(rx_chan_sel) >= fill_r) || (8'(rx_chan_sel) >= rx_pkt_size);
        end
    end

    assign rx_chan_data = zero_r ? 32'h0000_0000 : core.rd_data;
    assign header_found = state_r == framer_pkg::RX_CMD || state_r == framer_pkg::RX_CNT;
    assign rx_busy      = header_found || state_r == framer_pkg::RX_DATA;

    // Destination binding; the last bind or clear always wins.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            target_ip_r    <= `FRM_TARGET_IP_RST;
            target_port_r  <= `FRM_TARGET_PORT_RST;
            target_valid_r <= 1'b0;
        end else if (cnt_byte && cmd_r == `FRM_CMD_BIND) begin
            target_ip_r    <= rx_src_ip;
            target_port_r  <= rx_src_port;
            target_valid_r <= 1'b1;
        end else if (cnt_byte && cmd_r == `FRM_CMD_CLEAR) begin
            target_ip_r    <= `FRM_TARGET_IP_RST;
            target_port_r  <= `FRM_TARGET_PORT_RST;
            target_valid_r <= 1'b0;
        end
    end

    assign tx_dst_ip    = target_ip_r;
    assign tx_dst_port  = target_port_r;
    assign target_valid = target_valid_r;

    assign send_rise = send && !send_prev_r;
    assign ver_set   = cnt_byte && cmd_r == `FRM_CMD_VERSION;
    assign start     = !core.tx_busy && target_valid_r && (ver_pend_r || send_pend_r);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            send_prev_r <= 1'b0;
        end else begin
            send_prev_r <= send;
        end
    end

    // A send edge during busy is dropped, as the circuit is not meant to issue one then.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            send_pend_r <= 1'b0;
        end else if (send_rise && !core.tx_busy && target_valid_r) begin
            send_pend_r <= 1'b1;
        end else if (start && !ver_pend_r) begin
            send_pend_r <= 1'b0;
        end else if (!target_valid_r) begin
            send_pend_r <= 1'b0;
        end
    end

    // A version query landing in the cycle its predecessor is served stays pending.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ver_pend_r <= 1'b0;
        end else if (ver_set) begin
            ver_pend_r <= 1'b1;
        end else if (start || !target_valid_r) begin
            ver_pend_r <= 1'b0;
        end
    end

    assign core.tx_start   = start;
    assign core.tx_version = ver_pend_r;
    assign core.tx_count   = tx_pkt_size;
    assign tx_busy         = core.tx_busy || send_pend_r || ver_pend_r;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mac_r <= FACTORY_MAC;
        end else begin
            mac_r <= mac_user_en ? mac_user : FACTORY_MAC;
        end
    end

    assign mac_addr = mac_r;

    sample_mem #(.AW(AW)) u_mem (
        .mclk (mclk),
        .mp   (core.mem)
    );

    packet_tx #(.PROTO_VERSION(PROTO_VERSION)) u_tx (
        .mclk     (mclk),
        .rstn     (rstn),
        .rq       (core.tx),
        .word_idx (tx_word_idx),
        .word_in  (tx_word_in),
        .tx_byte  (tx_byte),
        .tx_valid (tx_valid),
        .tx_ready (tx_ready)
    );

    property p_hdr_rise;
        @(posedge mclk) disable iff (!rstn)
        take && cur == framer_pkg::RX_SYNC_LO && rx_byte == `FRM_SYNC_LO |=> header_found;
    endproperty
    a_hdr_rise: assert property (p_hdr_rise) else $error("header not flagged");

    property p_hdr_drop;
        @(posedge mclk) disable iff (!rstn)
        cnt_byte |=> !header_found;
    endproperty
    a_hdr_drop: assert property (p_hdr_drop) else $error("header flag stuck");

    property p_abort;
        @(posedge mclk) disable iff (!rstn)
        rx_reset |=> !rx_busy && fill_r == $past(fill_r);
    endproperty
    a_abort: assert property (p_abort) else $error("abort mishandled");

    property p_bind;
        @(posedge mclk) disable iff (!rstn)
        cnt_byte && cmd_r == `FRM_CMD_BIND |=> target_valid && tx_dst_ip == $past(rx_src_ip);
    endproperty
    a_bind: assert property (p_bind) else $error("bind not taken");

    property p_clear;
        @(posedge mclk) disable iff (!rstn)
        cnt_byte && cmd_r == `FRM_CMD_CLEAR |=> !target_valid && tx_dst_port == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not taken");

    property p_no_tx_unbound;
        @(posedge mclk) disable iff (!rstn)
        !target_valid && !tx_busy |=> !tx_valid [*2];
    endproperty
    a_no_tx_unbound: assert property (p_no_tx_unbound) else $error("sent while unbound");

    property p_send_busy;
        @(posedge mclk) disable iff (!rstn)
        send_rise && !tx_busy && target_valid |=> tx_busy;
    endproperty
    a_send_busy: assert property (p_send_busy) else $error("send edge ignored");

    property p_surplus_zero;
        @(posedge mclk) disable iff (!rstn)
        8'(rx_chan_sel) >= fill_r |=> rx_chan_data == 32'h0000_0000;
    endproperty
    a_surplus_zero: assert property (p_surplus_zero) else $error("surplus channel not zero");

    property p_version_reply;
        @(posedge mclk) disable iff (!rstn)
        ver_set && target_valid && !tx_busy |=> ##[1:3] (tx_valid && tx_byte == `FRM_SYNC_HI);
    endproperty
    a_version_reply: assert property (p_version_reply) else $error("no version reply");

    c_bind:  cover property (@(posedge mclk) disable iff (!rstn) cnt_byte && cmd_r == `FRM_CMD_BIND);
    c_data:  cover property (@(posedge mclk) disable iff (!rstn) core.wr_en && widx_r == cnt_r - 8'h01);
    c_abort: cover property (@(posedge mclk) disable iff (!rstn) rx_reset && rx_busy);
    c_send:  cover property (@(posedge mclk) disable iff (!rstn) start && !ver_pend_r);
endmodule : channel_packet_framer

`default_nettype wire

/* host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic        mclk,
    // Towards the device
    output logic      [7:0]  rx_byte,
    output logic             rx_valid,
    output logic             rx_first,
    output logic      [31:0] rx_src_ip,
    output logic      [15:0] rx_src_port,
    // From the device
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_valid,
    output logic             tx_ready
);
    logic [7:0] got_q[$];
    initial begin
        {rx_byte, rx_valid, rx_first, rx_src_ip, rx_src_port, tx_ready} = '0;
    end
    // Source fields are held for the whole datagram, bytes go back to back.
    task automatic send_dg(input logic [7:0] b[$], input logic [31:0] ip, input logic [15:0] pt);
        for (int i = 0; i < b.size(); i++) begin
            @(posedge mclk);
            #2;
            rx_src_ip   = ip;
            rx_src_port = pt;
            rx_byte     = b[i];
            rx_valid    = 1'b1;
            rx_first    = (i == 0);
        end
        @(posedge mclk);
        #2;
        rx_valid = 1'b0;
        rx_first = 1'b0;
        // A released line must not keep showing the last byte.
        rx_byte  = ~rx_byte;
    endtask : send_dg
    // Random stalls test held bytes as well as moving ones.
    always @(posedge mclk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back(tx_byte);
        end
        #2;
        tx_ready = ($urandom % 3) != 0;
    end
endmodule : host_model
`default_nettype wire

/* channel_packet_framer_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(64'(g), 64'(e))
module channel_packet_framer_bench;
    localparam logic [31:0] PV   = 32'h0000_0102;
    // Arbitrary value.
    localparam logic [47:0] FMAC = 48'h0A_1B_2C_3D_4E_5F;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  rx_byte, tx_byte, tx_pkt_size, rx_pkt_size, tx_word_idx, rx_chan_sel;
    logic [31:0] rx_src_ip, tx_dst_ip, tx_word_in, rx_chan_data, ip;
    logic [15:0] rx_src_port, tx_dst_port, pt;
    logic [47:0] mac_user, mac_addr;
    logic        rx_valid, rx_first, tx_valid, tx_ready, target_valid, send, tx_busy;
    logic        rx_reset, header_found, rx_busy, mac_user_en;
    logic [31:0] samp [0:255];
    logic [31:0] ch [0:15];
    logic [7:0]  pk[$], ex[$];
    logic [1:0]  fl[$];
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          fill = 0;
    always #12.5 mclk = ~mclk;
    assign tx_word_in = samp[tx_word_idx];
    always @(posedge mclk) if (rx_valid === 1'b1) fl.push_back({header_found, rx_busy});
    host_model i_host_model (
        .mclk(mclk), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first),
        .rx_src_ip(rx_src_ip), .rx_src_port(rx_src_port), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    channel_packet_framer #(.AW(8), .PROTO_VERSION(PV), .FACTORY_MAC(FMAC))
    i_channel_packet_framer (
        .mclk(mclk), .rstn(rstn), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first),
        .rx_src_ip(rx_src_ip), .rx_src_port(rx_src_port), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_dst_ip(tx_dst_ip),
        .tx_dst_port(tx_dst_port), .target_valid(target_valid), .send(send),
        .tx_pkt_size(tx_pkt_size), .tx_word_idx(tx_word_idx), .tx_word_in(tx_word_in),
        .tx_busy(tx_busy), .rx_reset(rx_reset), .rx_pkt_size(rx_pkt_size),
        .header_found(header_found), .rx_busy(rx_busy), .rx_chan_sel(rx_chan_sel),
        .rx_chan_data(rx_chan_data), .mac_user(mac_user), .mac_user_en(mac_user_en),
        .mac_addr(mac_addr));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask : chk
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : tk
    task automatic hd(ref logic [7:0] q[$], input logic [7:0] c, input logic [7:0] n);
        q = {8'h55, 8'hAA, c, n};
    endtask : hd
    task automatic pw(ref logic [7:0] q[$], input logic [31:0] w);
        for (int i = 3; i >= 0; i--) q.push_back(w[8*i +: 8]);
    endtask : pw
    // The cut trims bytes off the tail to model a truncated datagram.
    task automatic rx_dg(input logic [7:0] c, input int n, input int cut);
        logic [31:0] w;
        hd(pk, c, 8'(n));
        for (int k = 0; k < n; k++) begin
            w = $urandom;
            pw(pk, w);
            if (c == 8'h00) ch[k] = w;
        end
        if (c == 8'h00) fill = n - (cut + 3) / 4;
        repeat (cut) void'(pk.pop_back());
        fl = {};
        i_host_model.send_dg(pk, ip, pt);
    endtask : rx_dg
    task automatic rd_all;
        for (int k = 0; k < 5; k++) begin
            rx_chan_sel = 8'(k);
            tk(1);
            `CHK(rx_chan_data, (k < fill && k < rx_pkt_size) ? ch[k] : 32'h0);
        end
    endtask : rd_all
    // The tail wait catches a second, unwanted packet.
    task automatic tx_chk;
        int t = 0;
        while (i_host_model.got_q.size() < ex.size() && t < 300) begin
            tk(1);
            t++;
        end
        if (i_host_model.got_q.size() < ex.size()) begin
            n_mismatch++;
            test_done();
        end
        foreach (ex[i]) `CHK(i_host_model.got_q[i], ex[i]);
        tk(20);
        `CHK(i_host_model.got_q.size(), ex.size());
        i_host_model.got_q = {};
    endtask : tx_chk
    initial begin
        void'($urandom(32'hA08F));
        {send, rx_reset, mac_user_en, rx_chan_sel, mac_user} = '0;
        tx_pkt_size = 8'h00;
        rx_pkt_size = 8'h04;
        foreach (samp[i]) samp[i] = $urandom;
        ip = $urandom;
        pt = 16'($urandom);
        repeat (12) @(posedge mclk);
        #2;
        rstn = 1'b1;
        tk(1);
        `CHK(mac_addr, FMAC);
        `CHK({tx_valid, target_valid, header_found, rx_busy, tx_busy}, 5'h00);
        `CHK(rx_chan_data, 32'h0);
        rx_dg(8'h01, 0, 0);
        ex = {};
        tx_chk();
        rx_dg(8'h02, 0, 0);
        tk(1);
        `CHK({target_valid, tx_dst_ip, tx_dst_port}, {1'b1, ip, pt});
        rx_dg(8'h01, 0, 0);
        hd(ex, 8'h01, 8'h01);
        pw(ex, PV);
        tx_chk();
        rx_dg(8'h00, 3, 0);
        foreach (fl[i]) begin
            `CHK(fl[i][1], i == 2 || i == 3);
            `CHK(fl[i][0], i >= 2);
        end
        `CHK(rx_busy, 1'b0);
        for (int s = 4; s >= 2; s -= 2) begin
            rx_pkt_size = 8'(s);
            rd_all();
        end
        rx_dg(8'h00, 3, 6);
        rx_reset = 1'b1;
        tk(1);
        rx_reset = 1'b0;
        `CHK(rx_busy, 1'b0);
        rd_all();
        rx_dg(8'h00, 2, 0);
        rd_all();
        for (int n = 0; n <= 3; n += 3) begin
            tx_pkt_size = 8'(n);
            send = 1'b1;
            tk(2);
            `CHK(tx_busy, 1'b1);
            send = 1'b0;
            tk(1);
            // A second rise while busy must be dropped.
            send = 1'b1;
            tk(1);
            send = 1'b0;
            hd(ex, 8'h00, 8'(n));
            for (int k = 0; k < n; k++) pw(ex, samp[k]);
            tx_chk();
        end
        ip = $urandom;
        pt = 16'($urandom);
        rx_dg(8'h02, 0, 0);
        tk(1);
        `CHK({target_valid, tx_dst_ip, tx_dst_port}, {1'b1, ip, pt});
        rx_dg(8'h03, 0, 0);
        tk(1);
        `CHK({target_valid, tx_dst_ip, tx_dst_port}, 49'h0);
        send = 1'b1;
        tk(2);
        send = 1'b0;
        ex = {};
        tx_chk();
        hd(pk, 8'h02, 8'h00);
        pk[1] = 8'hA5;
        i_host_model.send_dg(pk, ip, pt);
        rx_dg(8'h07, 1, 0);
        tk(1);
        `CHK(target_valid, 1'b0);
        rd_all();
        mac_user = 48'({$urandom, $urandom});
        mac_user_en = 1'b1;
        tk(2);
        `CHK(mac_addr, mac_user);
        test_done();
    end
endmodule : channel_packet_framer_bench
`default_nettype wire
